/* File: rtl/wdt_device.sv */
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
// Contract
// RL1: three-bit select picks one of eight taps
// RL2: interval mode requests once per overflow period
// RL3: counter and control writes need word access
// RL4: shared write address, high byte is key
// RL5: byte reads at two adjacent addresses
// RL6: watchdog starts with mode and run set
// RL7: software rewrites counter periodically
// RL8: watchdog overflow: 518-clock reset or NMI
// RL9: watchdog NMI shares external NMI vector
// RL10: flag tells watchdog from pin reset
// RL11: mode zero with run is interval timer
// RL12: overflow sets flag and issues request
// RL13: counter write beats coincident increment
// RL14: stop timer before changing clock select
// RL15: standby recovery keeps only clock select
// RL16: run zero holds counter at zero
// RL17: flag clears by read-set then write zero
// RL18: select bit: zero NMI, one chip reset
// RL19: chip reset clears all; bit 4 reads one
// RL20: unknown key updates nothing
module wdt_device #(
   parameter int unsigned RESET_CYCLES = wdt_pkg::CHIP_RESET_CYCLES
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic standby_recover_in,
   wdt_bus_if.dev bus,
   output logic interval_irq_out,
   output logic nmi_req_out,
   output logic chip_reset_out,
   output logic external_reset_source_flag_out
);
   typedef enum logic [1:0] {
      S_NORMAL = 2'b01,
      S_CHIPRST = 2'b10
   } seq_state_t;

   if (RESET_CYCLES < 1 || RESET_CYCLES > (1 << wdt_pkg::RC_W)) begin : g_chk
      $error("RESET_CYCLES out of range");
   end

   seq_state_t state_q;
   logic [wdt_pkg::RC_W-1:0] rc_q;
   logic [wdt_pkg::PRE_W-1:0] pre_q;
   logic [wdt_pkg::PRE_W-1:0] mask;
   logic [7:0] cnt_q;
   logic ovf_q;
   logic mode_q;
   logic run_q;
   logic rstsel_q;
   logic [wdt_pkg::CKS_W-1:0] cks_q;
   logic armed_q;
   logic ack_q;
   logic [7:0] rdata_q;
   logic external_reset_source_flag_q;
   logic nmi_q;
   logic irq_q;
   logic acc;
   logic wr_word;
   logic cnt_wr;
   logic csr_wr;
   logic rd_csr;
   logic rd_cnt;
   logic tick;
   logic overflow;
   logic wipe;
   logic [7:0] csr_view;
   logic [7:0] key;

   assign acc = bus.req & ~ack_q;
   assign key = bus.wdata[wdt_pkg::KEY_LSB +: 8];
   // RL3: byte writes refused
   assign wr_word = acc & bus.we & bus.word & (bus.addr == wdt_pkg::WRITE_ADDR);
   // RL4: key selects target
   // RL20: other keys match nothing
   assign cnt_wr = wr_word & (key == wdt_pkg::KEY_CNT);
   assign csr_wr = wr_word & (key == wdt_pkg::KEY_CSR);
   // RL5: byte reads at two addresses
   assign rd_csr = acc & ~bus.we & (bus.addr == wdt_pkg::READ_CSR_ADDR);
   assign rd_cnt = acc & ~bus.we & (bus.addr == wdt_pkg::READ_CNT_ADDR);
   assign wipe = (state_q == S_CHIPRST);

   // RL1: tap select from prescaler
   assign mask = wdt_pkg::TAP_MASK[cks_q];
   assign tick = ((pre_q & mask) == mask);

   // RL12: overflow from FF to 00
   // RL13: counter write suppresses increment
   assign overflow = run_q & tick & (cnt_q == wdt_pkg::CNT_MAX) & ~cnt_wr & ~wipe
      & ~standby_recover_in;

   // RL19: reserved bit reads one
   always_comb begin
      csr_view = wdt_pkg::CSR_RESET;
      csr_view[wdt_pkg::OVF_BIT] = ovf_q;
      csr_view[wdt_pkg::MODE_BIT] = mode_q;
      csr_view[wdt_pkg::RUN_BIT] = run_q;
      csr_view[wdt_pkg::RSTSEL_BIT] = rstsel_q;
      csr_view[wdt_pkg::CKS_LSB +: wdt_pkg::CKS_W] = cks_q;
   end

   assign bus.ack = ack_q;
   assign bus.rdata = rdata_q;
   assign interval_irq_out = irq_q;
   assign nmi_req_out = nmi_q;
   assign chip_reset_out = wipe;
   assign external_reset_source_flag_out = external_reset_source_flag_q;

   // Bus answer one cycle after request
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ack_q <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         ack_q <= acc;
         if (rd_csr) begin
            rdata_q <= csr_view;
         end else if (rd_cnt) begin
            rdata_q <= cnt_q;
         end else if (acc) begin
            rdata_q <= 8'h00;
         end
      end
   end

   // Free-running prescaler
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pre_q <= '0;
      end else begin
         pre_q <= pre_q + 1'b1;
      end
   end

   // Counter
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_q <= wdt_pkg::CNT_RESET;
      end else if (wipe || standby_recover_in) begin
         // RL15: counter reset on recovery
         cnt_q <= wdt_pkg::CNT_RESET;
      end else if (!run_q) begin
         // RL16: stopped counter held cleared
         cnt_q <= wdt_pkg::CNT_RESET;
      end else if (cnt_wr) begin
         // RL13: write wins
         cnt_q <= bus.wdata[7:0];
      end else if (tick) begin
         cnt_q <= cnt_q + 8'h01;
      end
   end

   // Control bits
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mode_q <= 1'b0;
         run_q <= 1'b0;
         rstsel_q <= 1'b0;
         cks_q <= '0;
      end else if (wipe) begin
         // RL19: chip reset clears select too
         mode_q <= 1'b0;
         run_q <= 1'b0;
         rstsel_q <= 1'b0;
         cks_q <= '0;
      end else if (standby_recover_in) begin
         // RL15: clock select retained
         mode_q <= 1'b0;
         run_q <= 1'b0;
         rstsel_q <= 1'b0;
      end else if (csr_wr) begin
         // RL6: mode and run set start watchdog
         mode_q <= bus.wdata[wdt_pkg::MODE_BIT];
         run_q <= bus.wdata[wdt_pkg::RUN_BIT];
         rstsel_q <= bus.wdata[wdt_pkg::RSTSEL_BIT];
         cks_q <= bus.wdata[wdt_pkg::CKS_LSB +: wdt_pkg::CKS_W];
      end
   end

   // Overflow flag, set beats clear
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ovf_q <= 1'b0;
         armed_q <= 1'b0;
      end else if (wipe || standby_recover_in) begin
         ovf_q <= 1'b0;
         armed_q <= 1'b0;
      end else if (overflow) begin
         // RL12: flag set on overflow
         ovf_q <= 1'b1;
      end else if (rd_csr && ovf_q) begin
         armed_q <= 1'b1;
      end else if (csr_wr && armed_q && !bus.wdata[wdt_pkg::OVF_BIT]) begin
         // RL17: clear after read of set flag
         ovf_q <= 1'b0;
         armed_q <= 1'b0;
      end
   end

   // Overflow requests
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_q <= 1'b0;
         nmi_q <= 1'b0;
      end else begin
         // RL2: one request per overflow period
         // RL11: interval mode request
         irq_q <= overflow & ~mode_q;
         // RL9: NMI pulse to shared NMI vector
         // RL18: select zero gives NMI
         nmi_q <= overflow & mode_q & ~rstsel_q;
      end
   end

   // Chip reset sequencer
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q <= S_NORMAL;
         rc_q <= '0;
      end else begin
         case (state_q)
            S_NORMAL: begin
               // RL8: watchdog overflow with select one
               if (overflow && mode_q && rstsel_q) begin
                  state_q <= S_CHIPRST;
                  rc_q <= wdt_pkg::RC_W'(RESET_CYCLES - 1);
               end
            end
            S_CHIPRST: begin
               // RL8: held for the full count
               if (rc_q == '0) begin
                  state_q <= S_NORMAL;
               end else begin
                  rc_q <= rc_q - 1'b1;
               end
            end
            default: state_q <= S_NORMAL;
         endcase
      end
   end

   // RL10: pin reset sets, watchdog reset clears
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         external_reset_source_flag_q <= 1'b1;
      end else if (wipe) begin
         external_reset_source_flag_q <= 1'b0;
      end
   end
endmodule

/* File: rtl/wdt_pkg.sv */
package wdt_pkg;
   // Shared write location and byte read locations
   localparam logic [15:0] WRITE_ADDR = 16'hFFA8;
   localparam logic [15:0] READ_CSR_ADDR = 16'hFFA8;
   localparam logic [15:0] READ_CNT_ADDR = 16'hFFA9;
   localparam logic [7:0] KEY_CNT = 8'h5A;
   localparam logic [7:0] KEY_CSR = 8'hA5;
   localparam int KEY_LSB = 8;
   // Control/status field positions
   localparam int OVF_BIT = 7;
   localparam int MODE_BIT = 6;
   localparam int RUN_BIT = 5;
   localparam int RSV_BIT = 4;
   localparam int RSTSEL_BIT = 3;
   localparam int CKS_LSB = 0;
   localparam int CKS_W = 3;
   localparam logic [7:0] CSR_RESET = 8'h10;
   localparam logic [7:0] CNT_RESET = 8'h00;
   localparam logic [7:0] CNT_MAX = 8'hFF;
   // Prescaler taps: divisor minus one per select code
   localparam int PRE_W = 12;
   localparam logic [PRE_W-1:0] TAP_MASK [8] = '{
      12'h001, 12'h01F, 12'h03F, 12'h07F,
      12'h0FF, 12'h1FF, 12'h7FF, 12'hFFF};
   // Internal chip reset length in system clocks
   localparam int CHIP_RESET_CYCLES = 518;
   localparam int RC_W = 10;
   // Host command registers on Wishbone
   localparam logic [3:0] HR_ADDR = 4'h0;
   localparam logic [3:0] HR_WDATA = 4'h4;
   localparam logic [3:0] HR_CMD = 4'h8;
   localparam logic [3:0] HR_STATUS = 4'hC;
   localparam int CMD_WE_BIT = 0;
   localparam int CMD_WORD_BIT = 1;
   localparam int STAT_BUSY_BIT = 8;
endpackage

/* File: rtl/wdt_bus_if.sv */
`timescale 1ns/1ps
interface wdt_bus_if;
   logic req;
   logic we;
   logic word;
   logic [15:0] addr;
   logic [15:0] wdata;
   logic [7:0] rdata;
   logic ack;
   modport dev(input req, input we, input word, input addr, input wdata,
      output rdata, output ack);
   modport host(output req, output we, output word, output addr, output wdata,
      input rdata, input ack);
endinterface

/* File: rtl/wdt_host.sv */
`timescale 1ns/1ps
module wdt_host (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [3:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   wdt_bus_if.host bus
);
   typedef enum logic [1:0] {
      H_IDLE = 2'b01,
      H_WAIT = 2'b10
   } host_state_t;

   host_state_t state_q;
   logic [15:0] addr_q;
   logic [15:0] wdata_q;
   logic we_q;
   logic word_q;
   logic [7:0] rdata_q;
   logic wb_ack_q;
   logic [31:0] wb_dat_q;
   logic wb_acc;
   logic wr_cmd;

   assign wb_acc = wb_cyc_in & wb_stb_in & ~wb_ack_q;
   assign wr_cmd = wb_acc & wb_we_in & (wb_adr_in == wdt_pkg::HR_CMD) & wb_sel_in[0];
   assign wb_ack_out = wb_ack_q;
   assign wb_dat_out = wb_dat_q;
   assign bus.req = (state_q == H_WAIT);
   assign bus.addr = addr_q;
   assign bus.wdata = wdata_q;
   assign bus.we = we_q;
   assign bus.word = word_q;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wb_ack_q <= 1'b0;
         wb_dat_q <= 32'h0000_0000;
      end else begin
         wb_ack_q <= wb_acc;
         wb_dat_q <= 32'h0000_0000;
         if (wb_acc && !wb_we_in) begin
            case (wb_adr_in)
               wdt_pkg::HR_ADDR: wb_dat_q <= {16'h0000, addr_q};
               wdt_pkg::HR_WDATA: wb_dat_q <= {16'h0000, wdata_q};
               wdt_pkg::HR_CMD: wb_dat_q <= {30'h0000_0000, word_q, we_q};
               wdt_pkg::HR_STATUS: wb_dat_q <= {23'h00_0000, state_q == H_WAIT, rdata_q};
               default: wb_dat_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Address and word set up by software
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         addr_q <= 16'h0000;
         wdata_q <= 16'h0000;
      end else if (wb_acc && wb_we_in && state_q == H_IDLE) begin
         if (wb_adr_in == wdt_pkg::HR_ADDR) begin
            if (wb_sel_in[0]) addr_q[7:0] <= wb_dat_in[7:0];
            if (wb_sel_in[1]) addr_q[15:8] <= wb_dat_in[15:8];
         end
         // RL4: key in high byte
         if (wb_adr_in == wdt_pkg::HR_WDATA) begin
            if (wb_sel_in[0]) wdata_q[7:0] <= wb_dat_in[7:0];
            if (wb_sel_in[1]) wdata_q[15:8] <= wb_dat_in[15:8];
         end
      end
   end

   // Bus transfer: hold request until acknowledged
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q <= H_IDLE;
         we_q <= 1'b0;
         word_q <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         case (state_q)
            H_IDLE: begin
               if (wr_cmd) begin
                  we_q <= wb_dat_in[wdt_pkg::CMD_WE_BIT];
                  // RL3: word size for writes
                  word_q <= wb_dat_in[wdt_pkg::CMD_WORD_BIT];
                  state_q <= H_WAIT;
               end
            end
            H_WAIT: begin
               if (bus.ack) begin
                  if (!we_q) rdata_q <= bus.rdata;
                  state_q <= H_IDLE;
               end
            end
            default: state_q <= H_IDLE;
         endcase
      end
   end
endmodule

/* File: verif/wdt_assertions.sv */
`timescale 1ns/1ps
module wdt_checker #(
   parameter int unsigned RESET_CYCLES = wdt_pkg::CHIP_RESET_CYCLES
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic req,
   input wire logic we,
   input wire logic word,
   input wire logic [15:0] addr,
   input wire logic [15:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic ack,
   input wire logic interval_irq_out,
   input wire logic nmi_req_out,
   input wire logic chip_reset_out
);
   logic [wdt_pkg::RC_W:0] rc_q;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // Length of the current chip reset
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) rc_q <= '0;
      else if (chip_reset_out) rc_q <= rc_q + 1'b1;
      else rc_q <= '0;
   end
   a_ack_follows_req: assert property (req && !ack |=> ack)
      else $error("ack missing after request");
   a_ack_single_pulse: assert property (ack |=> !ack)
      else $error("ack longer than one cycle");
   a_req_held_stable: assert property (req && !ack |=> $stable(addr) && $stable(wdata)
      && $stable(we) && $stable(word))
      else $error("request changed before ack");
   a_reserved_reads_one: assert property (ack && !we
      && addr == wdt_pkg::READ_CSR_ADDR |-> rdata[4])
      else $error("reserved bit read as zero");
   a_unmapped_reads_zero: assert property (ack && !we && addr != wdt_pkg::READ_CSR_ADDR
      && addr != wdt_pkg::READ_CNT_ADDR |-> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_reset_exact_length: assert property ($fell(chip_reset_out) |-> rc_q == RESET_CYCLES)
      else $error("chip reset length wrong");
   a_reset_never_long: assert property (rc_q <= RESET_CYCLES)
      else $error("chip reset too long");
   a_one_request_kind: assert property (!(interval_irq_out && nmi_req_out))
      else $error("two overflow requests at once");
   a_nmi_single_pulse: assert property (nmi_req_out |=> !nmi_req_out)
      else $error("nmi request too long");
   a_irq_single_pulse: assert property (interval_irq_out |=> !interval_irq_out)
      else $error("interval request too long");
   c_interval: cover property (interval_irq_out);
   c_nmi: cover property (nmi_req_out);
   c_chip_reset: cover property ($fell(chip_reset_out));
endmodule

/* File: verif/password_guarded_watchdog_timer_test.sv */
`timescale 1ns/1ps
module password_guarded_watchdog_timer_test;
   logic clk_in, rst_n_in, standby, cyc, stb, wwe, wack, irq, nmi, crst, xflag;
   logic [3:0] adr;
   logic [31:0] wdat, rdat;
   logic [7:0] q;
   int errors, checks_done, irq_n, nmi_n, n, irq0;
   int div [3] = '{2, 32, 64};
   wdt_bus_if bus_if();
   wdt_host u_wdt_host (.clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc),
      .wb_stb_in(stb), .wb_we_in(wwe), .wb_adr_in(adr), .wb_sel_in(4'hF),
      .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(wack), .bus(bus_if.host));
   wdt_device u_wdt_device (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .standby_recover_in(standby), .bus(bus_if.dev), .interval_irq_out(irq),
      .nmi_req_out(nmi), .chip_reset_out(crst), .external_reset_source_flag_out(xflag));
   wdt_checker #(.RESET_CYCLES(wdt_pkg::CHIP_RESET_CYCLES)) u_wdt_checker (.clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .req(bus_if.req), .we(bus_if.we), .word(bus_if.word), .addr(bus_if.addr),
      .wdata(bus_if.wdata), .rdata(bus_if.rdata), .ack(bus_if.ack),
      .interval_irq_out(irq), .nmi_req_out(nmi), .chip_reset_out(crst));
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      irq_n += (irq === 1'b1);
      nmi_n += (nmi === 1'b1);
   end
   task automatic stop_test();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic hang();
      errors++;
      stop_test();
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         $display("unexpected %s expected %0h seen %0h", s, e, g);
         errors++;
      end
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] r);
      int k;
      k = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      wwe <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_in);
         k++;
      end while (wack !== 1'b1 && k < 50);
      if (k >= 50) hang();
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic dev(input logic w, input logic k, input logic [15:0] a,
      input logic [15:0] d);
      logic [31:0] r;
      int t;
      wb(1'b1, wdt_pkg::HR_ADDR, {16'h0000, a}, r);
      wb(1'b1, wdt_pkg::HR_WDATA, {16'h0000, d}, r);
      wb(1'b1, wdt_pkg::HR_CMD, {30'h0, k, w}, r);
      t = 0;
      do begin
         wb(1'b0, wdt_pkg::HR_STATUS, 32'h0, r);
         t++;
      end while (r[8] !== 1'b0 && t < 20);
      if (t >= 20) hang();
      q = r[7:0];
   endtask
   task automatic wr(input logic [7:0] key, input logic [7:0] v);
      dev(1'b1, 1'b1, 16'hFFA8, {key, v});
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e, input string s);
      dev(1'b0, 1'b0, a, 16'h0000);
      chk(s, {24'h0, e}, {24'h0, q});
   endtask
   task automatic wait_ev(input int sel, input int lim);
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (!(sel == 0 ? irq === 1'b1 : sel == 1 ? nmi === 1'b1 : crst === 1'b1)
         && n < lim);
      if (n >= lim) hang();
   endtask
   initial begin
      rst_n_in = 1'b0;
      standby = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      wwe = 1'b0;
      adr = 4'h0;
      wdat = 32'h0;
      repeat (10) @(posedge clk_in);
      rst_n_in <= 1'b1;
      @(posedge clk_in);
      chk("pin reset source", 1, xflag);
      rd(16'hFFA8, 8'h10, "control reset");
      rd(16'hFFA9, 8'h00, "counter reset");
      rd(16'hFFAA, 8'h00, "unmapped read");
      wr(8'hA5, 8'h80);
      rd(16'hFFA8, 8'h10, "flag write one");
      wr(8'h33, 8'h2F);
      rd(16'hFFA8, 8'h10, "wrong key");
      dev(1'b1, 1'b0, 16'hFFA8, 16'hA52F);
      rd(16'hFFA8, 8'h10, "byte write");
      for (int i = 0; i < 3; i++) begin
         wr(8'hA5, {5'h00, i[2:0]});
         wr(8'hA5, {5'h04, i[2:0]});
         wait_ev(0, 40000);
         wait_ev(0, 40000);
         chk("interval period", 256 * div[i], n);
         wr(8'hA5, {5'h00, i[2:0]});
      end
      wr(8'hA5, 8'h00);
      rd(16'hFFA8, 8'h90, "flag kept");
      wr(8'hA5, 8'h00);
      rd(16'hFFA8, 8'h10, "flag cleared");
      rd(16'hFFA9, 8'h00, "counter stopped");
      wr(8'hA5, 8'h60);
      repeat (3) begin
         repeat (300) @(posedge clk_in);
         wr(8'h5A, 8'h00);
      end
      chk("kicked watchdog", 0, nmi_n);
      irq0 = irq_n;
      wait_ev(1, 600);
      chk("watchdog irq", irq0, irq_n);
      rd(16'hFFA8, 8'hF0, "watchdog flag");
      wr(8'hA5, 8'h40);
      wr(8'hA5, 8'h69);
      wait_ev(2, 9000);
      n = 0;
      while (crst === 1'b1 && n < 600) begin
         @(posedge clk_in);
         n++;
      end
      chk("chip reset length", wdt_pkg::CHIP_RESET_CYCLES, n);
      chk("watchdog source", 0, xflag);
      rd(16'hFFA8, 8'h10, "control after reset");
      wr(8'hA5, 8'h23);
      wr(8'h5A, 8'h5C);
      dev(1'b0, 1'b0, wdt_pkg::READ_CNT_ADDR, 16'h0000);
      chk("counter written", 1, q inside {8'h5C, 8'h5D});
      standby <= 1'b1;
      @(posedge clk_in);
      standby <= 1'b0;
      rd(16'hFFA8, 8'h13, "standby control");
      rd(16'hFFA9, 8'h00, "standby counter");
      stop_test();
   end
endmodule
